/* File: hdl/source_prescaler.sv */
// source_prescaler: makes oscillator, 2x, 4x and /256 enable pulses.
// assumes hclk runs at the 4x multiplier rate of the oscillator.
`timescale 1ns/1ps
module source_prescaler (
	input  wire logic   hclk,
	input  wire logic   hresetn,
	clk_tick_if.src     ticks
);
	typedef struct packed {
		logic [9:0] cnt;
	} pre_s;

	pre_s st_r;
	pre_s st_nxt;

	////////////////////////////////////////////////////////////////
	// free running count; 2x, osc and /256 pulses are decoded from it, 4x is held high
	always_comb begin
		st_nxt     = st_r;
		st_nxt.cnt = st_r.cnt + 10'h001; // wraps at 1024
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// osc and /256 share the counter so every /256 pulse is also an osc pulse
	assign ticks.mul4_tick   = 1'b1;
	assign ticks.mul2_tick   = st_r.cnt[0];
	assign ticks.osc_tick    = (st_r.cnt[1:0] == sysclk_pkg::OSC_LAST);
	assign ticks.div256_tick = (st_r.cnt == sysclk_pkg::PRESCALE_LAST);
endmodule // source_prescaler

/* File: hdl/system_clock_select_divider.sv */
// system_clock_select_divider: selects the system clock source, divides
// it into four state phases and holds the control registers on ahb-lite.
// assumes one hclk domain; every derived clock is an enable pulse.
// Operation
// [RQ1] three-way mux: multiplier, oscillator, oscillator/256
// [RQ2] timers clocked from selected system clock enable
// [RQ3] state generator always divides system clock by four
// [RQ4] decode select: 00 mult, 01 reserved, 10, 11
// [RQ5] factor bit one gives 4x, zero gives 2x
// [RQ6] reset select field is 10, divide by four
// [RQ7] new selection applies one machine cycle later
// [RQ8] division applies to every clocked function
// [RQ9] changes away from non-10 must go via 10
// [RQ10] enable changes only at 10, ring off; clear restarts timeout
// [RQ11] ready low while stabilizing; software cannot set it
// [RQ12] source switches only at machine cycle boundary
`timescale 1ns/1ps
module system_clock_select_divider (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             sys_clk_en,
	output logic             machine_cycle_en,
	output logic      [1:0]  state_phase,
	output logic      [1:0]  active_divide_select
);
	typedef struct packed {
		logic                 wr_pend;     // write data phase pending
		logic [7:0]           wr_addr;
		logic [1:0]           cd_req;      // accepted, not yet applied
		logic [1:0]           cd_act;      // drives the mux
		logic [1:0]           apply_wait;  // machine cycles left to apply
		logic                 mul_en;
		logic                 mul_fact;
		logic                 ring_mode;
		logic                 clk_rdy;
		logic [sysclk_pkg::STAB_W-1:0] stab_cnt;
		logic [1:0]           phase;
	} ctl_s;

	ctl_s st_r;
	ctl_s st_nxt;

	clk_tick_if ticks ();

	source_prescaler u_prescaler (
		.hclk    (hclk),
		.hresetn (hresetn),
		.ticks   (ticks)
	);

	logic       addr_ok;
	logic       sel_tick;
	logic       mc_end;
	logic [1:0] new_cd;
	logic [7:0] wbyte;

	////////////////////////////////////////////////////////////////
	// source mux on the active select, held steady within a cycle
	always_comb begin
		unique case (st_r.cd_act)
			sysclk_pkg::CD_MULT:    sel_tick = st_r.mul_fact ?
				ticks.mul4_tick : ticks.mul2_tick; // see [RQ1] see [RQ5]
			sysclk_pkg::CD_DIV1024: sel_tick = ticks.div256_tick; // see [RQ4]
			default:                sel_tick = ticks.osc_tick; // see [RQ1]
		endcase
	end

	assign addr_ok = hsel && hready && (htrans == sysclk_pkg::HTRANS_NONSEQ);
	assign mc_end  = sel_tick && (st_r.phase == sysclk_pkg::STATE_LAST);
	assign wbyte   = hwdata[7:0];
	assign new_cd  = {wbyte[sysclk_pkg::CD_HI_POS], wbyte[sysclk_pkg::CD_LO_POS]};

	////////////////////////////////////////////////////////////////
	// control state: bus writes, pending select, stabilization timer
	always_comb begin
		st_nxt = st_r;

		// four state phases per machine cycle, whatever the source
		if (sel_tick) begin
			st_nxt.phase = st_r.phase + 2'h1; // see [RQ3]
		end

		// stabilization timeout; only hardware raises ready
		if (!st_r.clk_rdy) begin
			if (st_r.stab_cnt == sysclk_pkg::STAB_W'(sysclk_pkg::STAB_CYCLES - 1)) begin
				st_nxt.clk_rdy = 1'b1; // see [RQ11]
			end else begin
				st_nxt.stab_cnt = st_r.stab_cnt + 1'b1;
			end
		end

		// apply a pending select at the second cycle end after the write,
		// so a full machine cycle always passes and no phase is cut short
		if (st_r.apply_wait != 2'h0 && mc_end) begin
			st_nxt.apply_wait = st_r.apply_wait - 2'h1; // see [RQ7]
			if (st_r.apply_wait == 2'h1) begin
				st_nxt.cd_act = st_r.cd_req; // see [RQ12]
			end
		end

		// address phase capture
		st_nxt.wr_pend = addr_ok && hwrite;
		if (addr_ok) begin
			st_nxt.wr_addr = haddr;
		end

		// write data phase
		if (st_r.wr_pend && st_r.wr_addr == sysclk_pkg::PWR_MGMT_OFS) begin
			// select changes: reserved and illegal jumps are dropped
			if (new_cd != st_r.cd_req && new_cd != sysclk_pkg::CD_RESVD
				&& (st_r.cd_req == sysclk_pkg::CD_DIV4
				|| new_cd == sysclk_pkg::CD_DIV4) // see [RQ9]
				&& (new_cd != sysclk_pkg::CD_MULT
				|| (st_r.clk_rdy && st_r.mul_en))) begin // see [RQ11]
				st_nxt.cd_req     = new_cd; // see [RQ4]
				st_nxt.apply_wait = 2'h2; // see [RQ7]
			end
			// enable only moves at divide-by-4 with ring mode off
			if (st_r.cd_req == sysclk_pkg::CD_DIV4 && st_r.cd_act ==
				sysclk_pkg::CD_DIV4 && !st_r.ring_mode) begin // see [RQ10]
				st_nxt.mul_en = wbyte[sysclk_pkg::MUL_EN_POS];
				if (st_r.mul_en && !wbyte[sysclk_pkg::MUL_EN_POS]) begin
					st_nxt.clk_rdy  = 1'b0; // see [RQ10]
					st_nxt.stab_cnt = '0;
				end
			end
			// factor only changes while the multiplier is off
			if (!st_r.mul_en) begin
				st_nxt.mul_fact = wbyte[sysclk_pkg::MUL_FACT_POS]; // see [RQ5]
			end
		end else if (st_r.wr_pend && st_r.wr_addr == sysclk_pkg::CLK_RDY_OFS) begin
			// ready bit is read only; ring mode is stored and blocks enable changes
			st_nxt.ring_mode = wbyte[sysclk_pkg::RING_MODE_POS];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r            <= '0;
			st_r.cd_req     <= sysclk_pkg::CD_RESET; // see [RQ6]
			st_r.cd_act     <= sysclk_pkg::CD_RESET; // see [RQ6]
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// read mux from register flops; zero wait, always okay
	always_comb begin
		hrdata = 32'h00000000;
		if (st_r.wr_addr == sysclk_pkg::PWR_MGMT_OFS) begin
			hrdata[sysclk_pkg::CD_HI_POS]    = st_r.cd_req[1];
			hrdata[sysclk_pkg::CD_LO_POS]    = st_r.cd_req[0];
			hrdata[sysclk_pkg::MUL_EN_POS]   = st_r.mul_en;
			hrdata[sysclk_pkg::MUL_FACT_POS] = st_r.mul_fact;
		end else if (st_r.wr_addr == sysclk_pkg::CLK_RDY_OFS) begin
			hrdata[sysclk_pkg::CLK_RDY_POS]   = st_r.clk_rdy;
			hrdata[sysclk_pkg::RING_MODE_POS] = st_r.ring_mode;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// timers and peripherals take the system clock enable
	assign sys_clk_en           = sel_tick; // see [RQ2] see [RQ8]
	assign machine_cycle_en     = mc_end; // see [RQ3]
	assign state_phase          = st_r.phase;
	assign active_divide_select = st_r.cd_act;
endmodule // system_clock_select_divider

/* File: pkg/clk_tick_if.sv */
// interface: one-cycle enable pulses from the source prescaler.
// assumes every pulse is on hclk and lasts one cycle.
`timescale 1ns/1ps
interface clk_tick_if;
	logic mul4_tick;  // 4x multiplier rate
	logic mul2_tick;  // 2x multiplier rate
	logic osc_tick;   // raw oscillator rate
	logic div256_tick; // oscillator / 256
	modport src (output mul4_tick, mul2_tick, osc_tick, div256_tick);
	modport dst (input mul4_tick, mul2_tick, osc_tick, div256_tick);
endinterface

/* File: pkg/sysclk_pkg.sv */
// package: register map, field positions, reset values and timing counts
// for the system clock select and divide block.
// assumes one 40 MHz clock; hclk stands for the 4x multiplier rate.
package sysclk_pkg;
	// register byte offsets
	localparam logic [7:0] PWR_MGMT_OFS  = 8'h00;
	localparam logic [7:0] CLK_RDY_OFS   = 8'h04;

	// power_management_reg fields
	localparam int CD_HI_POS     = 7;
	localparam int CD_LO_POS     = 6;
	localparam int MUL_EN_POS    = 4;
	localparam int MUL_FACT_POS  = 3;

	// clock_ready_control_reg fields
	localparam int CLK_RDY_POS   = 3;
	localparam int RING_MODE_POS = 2;

	// clock divide select codes
	localparam logic [1:0] CD_MULT     = 2'h0;
	localparam logic [1:0] CD_RESVD    = 2'h1;
	localparam logic [1:0] CD_DIV4     = 2'h2;
	localparam logic [1:0] CD_DIV1024  = 2'h3;
	localparam logic [1:0] CD_RESET    = CD_DIV4;

	// hclk cycles per oscillator clock, divide ratio of the slow path
	localparam logic [9:0] PRESCALE_LAST = 10'h3FF; // 4 * 256 - 1
	localparam logic [1:0] OSC_LAST      = 2'h3;    // 4x rate / 4
	localparam logic [1:0] STATE_LAST    = 2'h3;    // four phases

	// multiplier stabilization timeout
	localparam int CLK_PERIOD_NS = 25;
	localparam int STAB_TIME_NS  = 25600;
	localparam int STAB_CYCLES   = (STAB_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int STAB_W        = 11;

	// ahb-lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

/* File: tb/sysclk_monitor.sv */
// checker: port relations of the clock select and divide block
// assumes it is bound to the block and sees only its ports
`timescale 1ns/1ps
module sysclk_monitor (
	input wire logic       hclk,
	input wire logic       hresetn,
	input wire logic       sys_clk_en,
	input wire logic       machine_cycle_en,
	input wire logic [1:0] state_phase,
	input wire logic [1:0] active_divide_select
);
	wire       se  = sys_clk_en;
	wire       mc  = machine_cycle_en;
	wire [1:0] ph  = state_phase;
	wire [1:0] sel = active_divide_select;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	////////////////////////////////////////////////////////////////////////
	// state phases and machine cycle
	property p_mc; mc |-> se && ph == 2'h3; endproperty
	property p_adv; se |=> ph == $past(ph) + 2'h1; endproperty
	property p_hold; !se |=> $stable(ph); endproperty
	// select changes: only at a cycle boundary, never reserved, via 10
	property p_rsv; sel != 2'h1; endproperty
	property p_bnd; $changed(sel) |-> $past(mc); endproperty
	property p_via; $changed(sel) |-> sel == 2'h2 || $past(sel) == 2'h2;
	endproperty
	property p_rst; $rose(hresetn) |-> sel == 2'h2; endproperty
	// system clock rates per select code
	property p_d4; sel == 2'h2 && se && !mc |=> (!se)[*3] ##1 se; endproperty
	property p_mul; sel == 2'h0 && se && !mc |-> ##[1:2] se; endproperty
	property p_slow; sel == 2'h3 && se && !mc |=> (!se)[*8]; endproperty
	a_mc: assert property (p_mc) else $error("cycle end off phase 3");
	a_adv: assert property (p_adv) else $error("phase did not step");
	a_hold: assert property (p_hold) else $error("phase moved");
	a_rsv: assert property (p_rsv) else $error("reserved select");
	a_bnd: assert property (p_bnd) else $error("switch off edge");
	a_via: assert property (p_via) else $error("direct switch");
	a_rst: assert property (p_rst) else $error("bad reset select");
	a_d4: assert property (p_d4) else $error("div4 rate wrong");
	a_mul: assert property (p_mul) else $error("mult rate wrong");
	a_slow: assert property (p_slow) else $error("slow rate wrong");
	c_mul: cover property (sel == 2'h0 && se);
	c_slow: cover property (sel == 2'h3 && mc);
	c_back: cover property ($changed(sel) && sel == 2'h2);
endmodule // sysclk_monitor
bind system_clock_select_divider sysclk_monitor mon (.hclk(hclk),
	.hresetn(hresetn), .sys_clk_en(sys_clk_en),
	.machine_cycle_en(machine_cycle_en), .state_phase(state_phase),
	.active_divide_select(active_divide_select));

/* File: tb/tb_system_clock_select_divider.sv */
// testbench: register access, select sequencing and clock rates
// assumes the block alone, driven over ahb-lite by this bench
`timescale 1ns/1ps
module tb_system_clock_select_divider;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rd = 0;
	logic [7:0]  haddr = 8'h00;
	logic [1:0]  htrans = 2'h0, sel;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0, hrdata, q[$];
	logic        hreadyout, se;
	int          err_count = 0, checks = 0, seed = 32'ha90b, r;
	system_clock_select_divider dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(), .sys_clk_en(se),
		.machine_cycle_en(), .state_phase(), .active_divide_select(sel));
	initial forever #12.5 hclk = ~hclk;
	////////////////////////////////////////////////////////////////////////
	task check(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, s, e);
		end
	endtask
	task test_done;
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// one edge at a time until hready, bounded
	task wrdy;
		int n;
		n = 0;
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) begin err_count++; test_done; end
	endtask
	// single word transfer; a read notes its expected data
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		r = $random(seed);
		hsel <= 1'b1; htrans <= sysclk_pkg::HTRANS_NONSEQ;
		haddr <= a; hwrite <= w;
		wrdy;
		hsel <= 1'b0; htrans <= 2'h0; rd <= !w;
		hwdata <= w ? {r[31:8], d[7:0]} : r;
		if (!w) q.push_back(d);
		wrdy;
		rd <= 1'b0;
	endtask
	// cycles between two system clock pulses, bounded
	task per(input int e);
		int n, k;
		for (k = 0; k < 2; k++) begin
			n = 0;
			do begin @(posedge hclk); n++; end while (!se && n < 2000);
		end
		check(n, e);
	endtask
	// read data is compared against the oldest note
	always @(posedge hclk) if (rd) check(hrdata, q.pop_front());
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		bus(0, 8'h00, 32'h80);
		bus(1, 8'h04, 32'h08); bus(0, 8'h04, 32'h00);
		bus(1, 8'h00, 32'h00); bus(0, 8'h00, 32'h80);
		per(4);
		repeat (1100) @(posedge hclk);
		bus(0, 8'h04, 32'h08);
		bus(1, 8'h00, 32'h88); bus(1, 8'h00, 32'h98); bus(1, 8'h00, 32'h18);
		check(sel, 2'h2);
		repeat (40) @(posedge hclk);
		check(sel, 2'h0); per(1);
		bus(1, 8'h00, 32'hD8); bus(0, 8'h00, 32'h18);
		bus(1, 8'h00, 32'h98); repeat (40) @(posedge hclk); per(4);
		bus(1, 8'h00, 32'hD8); bus(0, 8'h00, 32'hD8);
		repeat (40) @(posedge hclk);
		check(sel, 2'h3); per(1024);
		bus(1, 8'h00, 32'h58); bus(0, 8'h00, 32'hD8);
		bus(1, 8'h00, 32'h98); repeat (8300) @(posedge hclk);
		check(sel, 2'h2);
		bus(1, 8'h00, 32'h88); bus(0, 8'h04, 32'h00);
		bus(1, 8'h00, 32'h80); repeat (1100) @(posedge hclk);
		bus(1, 8'h00, 32'h90); bus(1, 8'h00, 32'h10);
		repeat (40) @(posedge hclk);
		per(2);
		r = $random(seed);
		bus(0, 8'h08 + (r[7:0] & 8'hF0), 32'h0);
		repeat (2) @(posedge hclk);
		test_done;
	end
endmodule // tb_system_clock_select_divider
